// file: psbrc_top.sv
// Power sequencer, power-on acknowledge and reset level controller
`timescale 1ns/10ps
`default_nettype none
module psbrc_top #(
   parameter int unsigned HOLD_CYCLES = psbrc_pkg::HOLD_CYCLES,
   parameter logic [6:0]  VOLTAGE_SELECT_FIELD_SET0   = 7'h20,
   parameter logic [6:0]  VOLTAGE_SELECT_FIELD_SET1   = 7'h30
) (
   // Clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rstn,
   // Wishbone slave
   input  wire psbrc_pkg::psbrc_wb_req_t i_wb,
   output var  psbrc_pkg::psbrc_wb_rsp_t o_wb,
   // Pins
   input  wire logic                     i_hold_on_pin,
   input  wire logic                     i_power_button_pin,
   input  wire logic                     i_config_set_strap,
   input  wire logic                     i_sequence_select_strap,
   input  wire logic                     i_osc_stable,
   input  wire logic                     i_ext_clk_stable,
   // Outputs
   output logic [7:0]                    o_resource_en,
   output logic                          o_proc_reset_n,
   output logic                          o_seq_busy
);

   // ==========================================================
   // State
   typedef struct packed {
      psbrc_pkg::psbrc_state_t           st;
      logic [3:0]                        pc;
      logic [1:0]                        seq;
      logic [7:0]                        dly;
      logic [psbrc_pkg::TICK_W-1:0]      tick;
      logic [psbrc_pkg::WIN_W-1:0]       win;
      logic                              grace_done;
      logic                              was_on;
      logic                              lvl_hw;
      logic [psbrc_pkg::NPIN-1:0]        m1;
      logic [psbrc_pkg::NPIN-1:0]        m2;
      logic                              hold_d;
      logic                              btn_d;
      logic                              cfg_set;
      logic                              seq_sel;
      logic [psbrc_pkg::CTL_W-1:0]       ctl;
      logic [7:0]                        res;
      logic [6:0]                        voltage_select_field;
      logic [6:0]                        fvsel;
      logic [1:0]                        last_lvl;
      logic                              proc_rstn;
      logic                              ack;
      logic [31:0]                       rdat;
   } psbrc_regs_t;

   psbrc_regs_t s_reg;
   psbrc_regs_t s_next;
   logic [15:0] prog_mem [psbrc_pkg::PROG_DEPTH];

   logic                       wb_req;
   logic                       wb_wr;
   logic                       prog_hit;
   logic [4:0]                 prog_idx;
   psbrc_pkg::psbrc_step_t     step;
   logic                       tick_en;
   logic                       clk_ok;
   logic                       on_any;
   logic [31:0]                prog_wv;

   function automatic logic [31:0] wmask(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Bus decode
   assign wb_req   = i_wb.cyc & i_wb.stb;
   // Writes take effect at the edge where ack is seen high
   assign wb_wr    = wb_req & i_wb.we & s_reg.ack;
   assign prog_hit = (i_wb.adr >= psbrc_pkg::PROG_BASE_OFS);
   assign prog_idx = i_wb.adr[6:2];
   assign prog_wv  = wmask({16'h0000, prog_mem[prog_idx]}, i_wb.dat,
                           i_wb.sel);

   assign step     = psbrc_pkg::psbrc_step_t'(prog_mem[{s_reg.seq,
                                                       s_reg.pc[2:0]}]);
   assign tick_en  = (s_reg.tick == psbrc_pkg::TICK_W'(
                         psbrc_pkg::TICK_DIV - 1));
   assign clk_ok = s_reg.ctl[psbrc_pkg::CTL_GATE_BYPASS]
      | (s_reg.m2[psbrc_pkg::PIN_OSC]
         & ~s_reg.ctl[psbrc_pkg::CTL_OSC_BYPASS])
      | (s_reg.m2[psbrc_pkg::PIN_EXT]
         & s_reg.ctl[psbrc_pkg::CTL_OSC_BYPASS]);
   assign on_any = s_reg.m2[psbrc_pkg::PIN_HOLD]
                 | s_reg.ctl[psbrc_pkg::CTL_KEEP_ON];

   // ==========================================================
   // Next state
   always_comb begin
      logic [31:0] wv;
      logic        off_req;
      logic        on_req;
      wv      = wmask(32'h0000_0000, i_wb.dat, i_wb.sel);
      off_req = 1'b0;
      on_req  = 1'b0;
      s_next  = s_reg;

      // Pin synchronisers
      s_next.m1 = {i_ext_clk_stable, i_osc_stable, i_sequence_select_strap,
                   i_config_set_strap, i_power_button_pin, i_hold_on_pin};
      s_next.m2     = s_reg.m1;
      s_next.hold_d = s_reg.m2[psbrc_pkg::PIN_HOLD];
      s_next.btn_d  = s_reg.m2[psbrc_pkg::PIN_BTN];
      on_req = (s_reg.m2[psbrc_pkg::PIN_BTN] & ~s_reg.btn_d)
             | (s_reg.m2[psbrc_pkg::PIN_HOLD] & ~s_reg.hold_d);

      // Slow tick divider
      s_next.tick = tick_en ? '0 : s_reg.tick + 1'b1;

      // Bus answer and read mux
      s_next.ack = wb_req & ~s_reg.ack;
      s_next.rdat = 32'h0000_0000;
      if (prog_hit) begin
         s_next.rdat = {16'h0000, prog_mem[prog_idx]};
      end else begin
         case (i_wb.adr)
            psbrc_pkg::DEVICE_CONTROL_REG_OFS:
               s_next.rdat = {26'h0, s_reg.ctl};
            psbrc_pkg::STATUS_REG_OFS:
               s_next.rdat = {24'h0, s_reg.seq_sel, s_reg.cfg_set,
                              s_reg.proc_rstn, o_seq_busy,
                              1'b0, 3'(s_reg.st)};
            psbrc_pkg::RESOURCE_REG_OFS:
               s_next.rdat = {24'h0, s_reg.res};
            psbrc_pkg::SWITCHER_VOLTAGE_OFS:
               s_next.rdat = {25'h0, s_reg.voltage_select_field};
            psbrc_pkg::SWITCHER_FORCED_OFS:
               s_next.rdat = {25'h0, s_reg.fvsel};
            psbrc_pkg::SWITCHOFF_STATUS_OFS:
               s_next.rdat = {30'h0, s_reg.last_lvl};
            default:
               s_next.rdat = 32'h0000_0000;
         endcase
      end

      // Software register writes
      if (wb_wr && !prog_hit) begin
         case (i_wb.adr)
            psbrc_pkg::DEVICE_CONTROL_REG_OFS: begin
               if (i_wb.sel[0]) begin
                  s_next.ctl = wv[psbrc_pkg::CTL_W-1:0];
               end
            end
            psbrc_pkg::RESOURCE_REG_OFS: begin
               // software only once sequencing is over
               if (i_wb.sel[0] && s_reg.st == psbrc_pkg::ST_ACTIVE) begin
                  s_next.res = wv[7:0];
               end
            end
            psbrc_pkg::SWITCHER_VOLTAGE_OFS: begin
               if (i_wb.sel[0]) begin
                  s_next.voltage_select_field = wv[6:0];
               end
            end
            psbrc_pkg::SWITCHER_FORCED_OFS: begin
               if (i_wb.sel[0]) begin
                  s_next.fvsel = wv[6:0];
               end
            end
            default: begin
            end
         endcase
      end

      // ==========================================================
      // Sequencer
      case (s_reg.st)
         psbrc_pkg::ST_BOOT: begin
            s_next.cfg_set = s_reg.m2[psbrc_pkg::PIN_CFG];
            s_next.seq_sel = s_reg.m2[psbrc_pkg::PIN_SEL];
            s_next.voltage_select_field  = s_reg.m2[psbrc_pkg::PIN_CFG] ? VOLTAGE_SELECT_FIELD_SET1
                                                        : VOLTAGE_SELECT_FIELD_SET0;
            s_next.fvsel = s_reg.m2[psbrc_pkg::PIN_CFG] ? VOLTAGE_SELECT_FIELD_SET1
                                                        : VOLTAGE_SELECT_FIELD_SET0;
            s_next.st = psbrc_pkg::ST_OFF;
         end
         psbrc_pkg::ST_OFF: begin
            if (on_req) begin
               if (s_reg.cfg_set) begin
                  s_next.seq = psbrc_pkg::SEQ_C;
               end else if (s_reg.seq_sel) begin
                  s_next.seq = psbrc_pkg::SEQ_B;
               end else begin
                  s_next.seq = psbrc_pkg::SEQ_A;
               end
               s_next.pc  = 4'h0;
               s_next.dly = 8'h00;
               s_next.st  = psbrc_pkg::ST_UP;
            end
         end
         psbrc_pkg::ST_UP,
         psbrc_pkg::ST_DOWN: begin
            if (s_reg.dly != 8'h00) begin
               if (tick_en) begin
                  s_next.dly = s_reg.dly - 1'b1;
               end
            end else if (s_reg.pc[3] || step.op == psbrc_pkg::OP_END
                         || step.op == 2'h3) begin
               s_next.pc = 4'h0;
               if (s_reg.st == psbrc_pkg::ST_UP) begin
                  // keep-on bit set at power-up end
                  if (s_reg.ctl[psbrc_pkg::CTL_AUTO_MODE]
                      && s_reg.ctl[psbrc_pkg::CTL_AUTO_SET]) begin
                     s_next.ctl[psbrc_pkg::CTL_KEEP_ON] = 1'b1;
                  end
                  s_next.st = psbrc_pkg::ST_WAIT_CLK;
               end else begin
                  s_next.res   = psbrc_pkg::RES_RST;
                  s_next.voltage_select_field  = s_reg.cfg_set ? VOLTAGE_SELECT_FIELD_SET1 : VOLTAGE_SELECT_FIELD_SET0;
                  s_next.fvsel = s_reg.cfg_set ? VOLTAGE_SELECT_FIELD_SET1 : VOLTAGE_SELECT_FIELD_SET0;
                  s_next.last_lvl = psbrc_pkg::LVL_SWO;
                  if (s_reg.lvl_hw) begin
                     s_next.ctl      = psbrc_pkg::CTL_RST;
                     s_next.last_lvl = psbrc_pkg::LVL_HW;
                  end
                  s_next.st = psbrc_pkg::ST_OFF;
               end
            end else if (step.op == psbrc_pkg::OP_SET) begin
               s_next.res[step.arg[2:0]] = step.val;
               s_next.dly = step.delay;
               s_next.pc  = s_reg.pc + 1'b1;
            end else begin
               if ((step.strap_sel ? s_reg.seq_sel : s_reg.cfg_set)
                   == step.val) begin
                  s_next.pc = {1'b0, step.arg[2:0]};
               end else begin
                  s_next.pc = s_reg.pc + 1'b1;
               end
            end
         end
         psbrc_pkg::ST_WAIT_CLK: begin
            // release with a ready clock or with the gate bypass bit set
            if (clk_ok) begin
               s_next.proc_rstn  = 1'b1;
               s_next.win        = '0;
               s_next.grace_done = 1'b0;
               s_next.was_on     = 1'b0;
               s_next.st         = psbrc_pkg::ST_ACTIVE;
            end
         end
         psbrc_pkg::ST_ACTIVE: begin
            if (!s_reg.grace_done) begin
               if (s_reg.win == psbrc_pkg::WIN_W'(HOLD_CYCLES - 1)) begin
                  s_next.grace_done = 1'b1;
               end else begin
                  s_next.win = s_reg.win + 1'b1;
               end
            end
            if (on_any) begin
               s_next.was_on = 1'b1;
            end
            // hold low after high is off
            // only when no on source remains
            off_req = ~on_any & (s_reg.grace_done | s_reg.was_on);
            if (off_req) begin
               s_next.proc_rstn = 1'b0;
               s_next.lvl_hw    = s_reg.ctl[psbrc_pkg::CTL_OFF_HARDWARE_RESET_LEVEL];
               s_next.seq       = psbrc_pkg::SEQ_OFF;
               s_next.pc        = 4'h0;
               s_next.dly       = 8'h00;
               s_next.st        = psbrc_pkg::ST_DOWN;
            end
         end
         default: begin
            s_next.st = psbrc_pkg::ST_BOOT;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         s_reg            <= '0;
         s_reg.st         <= psbrc_pkg::ST_BOOT;
         s_reg.ctl        <= psbrc_pkg::CTL_RST;
         s_reg.res        <= psbrc_pkg::RES_RST;
         s_reg.last_lvl   <= psbrc_pkg::LVL_POR;
         // Synchronisers keep sampling so straps are valid at boot
         s_reg.m1         <= s_next.m1;
         s_reg.m2         <= s_next.m2;
      end else begin
         s_reg <= s_next;
      end
   end

   // Sequence store, written over the bus, never reset
   always_ff @(posedge i_ref_clk) begin
      if (wb_wr && prog_hit) begin
         prog_mem[prog_idx] <= prog_wv[15:0];
      end
   end

   // ==========================================================
   // Outputs
   assign o_wb.ack       = s_reg.ack;
   assign o_wb.dat       = s_reg.rdat;
   assign o_resource_en  = s_reg.res;
   // reset high only in active state
   assign o_proc_reset_n = s_reg.proc_rstn;
   assign o_seq_busy     = (s_reg.st == psbrc_pkg::ST_UP)
                         | (s_reg.st == psbrc_pkg::ST_DOWN);

endmodule // psbrc_top
`default_nettype wire

// file: psbrc_pkg.sv
// Constants and types for the power sequence and boot reset controller
// Function
// - Resources no sequence touches stay off; software writes them only after sequencing.
// - Each set step carries its own wait before the next step; branch steps do not wait.
// - Processor reset released after start-up once oscillator or bypassed slow clock stable.
// - Gate bypass bit releases processor reset without any clock present.
// - Hold-pin mode: on request starts power-up; reset released in active state.
// - Hold-pin mode: shut down 8 s after active unless hold pin high.
// - Hold-pin mode: hold pin returning low is an off request.
// - Keep-on mode: keep-on bit set at power-up end; active until cleared.
// - Automatic set optional; disabled means hold-pin behaviour using the bit.
// - Each sequence is a stored list of resource register writes.
// - Statically loaded voltage settings stay writable by software; sequence steps write only resource bits.
// - Config set strap 0 selects set 0, 1 selects set 1.
// - Straps 00 give sequence A, 01 sequence B, 1x sequence C.
// - Normal and forced voltage fields load together from one stored value.
// - Sequence steps may branch on either strap value.
// - Level 0 reset clears every register class.
// - Level 1 reset runs off sequence, resets all but power-on class.
// - Level 2 reset runs off sequence, resets only switch-off class.
// - Voltage and resource registers are switch-off class; control register resets at level 0 and 1 only; status registers power-on class.
// - Shutdown only when neither hold pin nor keep-on bit keeps device active.
`default_nettype none
package psbrc_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned SLOW_HZ       = 32_768;
   localparam int unsigned TICK_DIV      = CLK_HZ / SLOW_HZ;
   localparam int unsigned HOLD_WINDOW_S = 8;
   localparam int unsigned HOLD_CYCLES   = HOLD_WINDOW_S * CLK_HZ;
   localparam int unsigned WIN_W         = 29;
   localparam int unsigned TICK_W        = 11;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] DEVICE_CONTROL_REG_OFS  = 8'h00;
   localparam logic [7:0] STATUS_REG_OFS          = 8'h04;
   localparam logic [7:0] RESOURCE_REG_OFS        = 8'h08;
   localparam logic [7:0] SWITCHER_VOLTAGE_OFS    = 8'h0C;
   localparam logic [7:0] SWITCHER_FORCED_OFS     = 8'h10;
   localparam logic [7:0] SWITCHOFF_STATUS_OFS    = 8'h14;
   localparam logic [7:0] PROG_BASE_OFS           = 8'h80;

   // ==========================================================
   // Device control fields and reset values
   localparam int unsigned CTL_KEEP_ON     = 0;
   localparam int unsigned CTL_AUTO_MODE   = 1;
   localparam int unsigned CTL_AUTO_SET    = 2;
   localparam int unsigned CTL_GATE_BYPASS = 3;
   localparam int unsigned CTL_OSC_BYPASS  = 4;
   localparam int unsigned CTL_OFF_HARDWARE_RESET_LEVEL   = 5;
   localparam int unsigned CTL_W           = 6;
   localparam logic [5:0]  CTL_RST         = 6'h06;
   localparam logic [7:0]  RES_RST         = 8'h00;
   localparam logic [1:0]  LVL_POR         = 2'h0;
   localparam logic [1:0]  LVL_HW          = 2'h1;
   localparam logic [1:0]  LVL_SWO         = 2'h2;

   // ==========================================================
   // Sequence store: 4 sequences of 8 steps
   localparam logic [1:0] SEQ_A   = 2'h0;
   localparam logic [1:0] SEQ_B   = 2'h1;
   localparam logic [1:0] SEQ_C   = 2'h2;
   localparam logic [1:0] SEQ_OFF = 2'h3;
   localparam int unsigned PROG_DEPTH = 32;
   localparam logic [1:0] OP_SET    = 2'h0;
   localparam logic [1:0] OP_BRANCH = 2'h1;
   localparam logic [1:0] OP_END    = 2'h2;

   typedef enum logic [2:0] {
      ST_BOOT, ST_OFF, ST_UP, ST_WAIT_CLK, ST_ACTIVE, ST_DOWN
   } psbrc_state_t;

   // Step: op, target (resource or jump), value, strap choice, delay
   typedef struct packed {
      logic [1:0] op;
      logic [3:0] arg;
      logic       val;
      logic       strap_sel;
      logic [7:0] delay;
   } psbrc_step_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } psbrc_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } psbrc_wb_rsp_t;

   // Pin synchroniser order
   localparam int unsigned PIN_HOLD = 0;
   localparam int unsigned PIN_BTN  = 1;
   localparam int unsigned PIN_CFG  = 2;
   localparam int unsigned PIN_SEL  = 3;
   localparam int unsigned PIN_OSC  = 4;
   localparam int unsigned PIN_EXT  = 5;
   localparam int unsigned NPIN     = 6;
endpackage
`default_nettype wire

// file: psbrc_properties.sv
// Port assertions for the power sequencer top
`timescale 1ns/10ps
`default_nettype none
module psbrc_properties (
   // Clock and reset
   input wire logic                     i_ref_clk,
   input wire logic                     i_rstn,
   // Bus
   input wire psbrc_pkg::psbrc_wb_req_t i_wb,
   input wire psbrc_pkg::psbrc_wb_rsp_t o_wb,
   // Pins
   input wire logic                     i_hold_on_pin,
   input wire logic                     i_power_button_pin,
   input wire logic                     i_config_set_strap,
   input wire logic                     i_sequence_select_strap,
   input wire logic                     i_osc_stable,
   input wire logic                     i_ext_clk_stable,
   input wire logic [7:0]               o_resource_en,
   input wire logic                     o_proc_reset_n,
   input wire logic                     o_seq_busy
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // ==========================================================
   // Sequences
   sequence s_req;
      i_wb.cyc && i_wb.stb && !o_wb.ack;
   endsequence
   sequence s_drop;
      o_proc_reset_n ##1 !o_proc_reset_n;
   endsequence
   // ==========================================================
   // Properties
   property p_ack_next;
      s_req |=> o_wb.ack;
   endproperty
   property p_ack_pulse;
      o_wb.ack |=> !o_wb.ack;
   endproperty
   property p_unmapped_zero;
      (s_req ##0 (i_wb.adr == 8'h40 && !i_wb.we))
         |=> o_wb.dat == 32'h0000_0000;
   endproperty
   property p_res_cause;
      $changed(o_resource_en)
         |-> $past(o_seq_busy) || $past(o_wb.ack && i_wb.we);
   endproperty
   property p_rel_idle;
      $rose(o_proc_reset_n) |-> !o_seq_busy;
   endproperty
   property p_busy_holds;
      o_seq_busy |-> !o_proc_reset_n;
   endproperty
   property p_off_runs;
      s_drop |-> o_seq_busy;
   endproperty
   property p_start_cause;
      $rose(o_seq_busy) && !$past(o_proc_reset_n)
         |-> $past(i_power_button_pin, 2) || $past(i_hold_on_pin, 2);
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   a_res_cause: assert property (p_res_cause)
      else $error("resource changed outside sequence or write");
   a_rel_idle: assert property (p_rel_idle)
      else $error("reset released before sequence done");
   a_busy_holds: assert property (p_busy_holds)
      else $error("reset released while sequencing");
   a_off_runs: assert property (p_off_runs)
      else $error("off without off sequence");
   a_start_cause: assert property (p_start_cause)
      else $error("power-up without on request");
endmodule // psbrc_properties
`default_nettype wire

// file: psbrc_host.sv
// Host processor model driving the hold-on pin
`timescale 1ns/10ps
`default_nettype none
module psbrc_host (
   // Clock, bench control and processor reset
   input  wire logic i_ref_clk,
   input  wire logic i_keep,
   input  wire logic i_proc_reset_n,
   // Pin into the device
   output logic      o_hold_on_pin
);
   logic [2:0] dly_reg  = 3'h0;
   logic       hold_reg = 1'b0;
   assign o_hold_on_pin = hold_reg;
   // raise after reset release, keep while wanted
   always_ff @(posedge i_ref_clk) begin
      if (!i_keep) begin
         dly_reg  <= 3'h0;
         hold_reg <= 1'b0;
      end else if (i_proc_reset_n) begin
         if (dly_reg != 3'h7) dly_reg <= dly_reg + 3'h1;
         else hold_reg <= 1'b1;
      end
   end
endmodule // psbrc_host
`default_nettype wire

// file: psbrc_top_tb.sv
// Self-checking bench for the power sequencer top
`timescale 1ns/10ps
`default_nettype none
module psbrc_top_tb;
   localparam int unsigned H  = 200;
   localparam logic [6:0]  V0 = 7'h25;
   localparam logic [6:0]  V1 = 7'h3A;
   logic clk = 1'b0, rstn = 1'b0, btn = 1'b0, osc = 1'b0;
   logic cfg = 1'b0, sqs = 1'b0, keep = 1'b0, ext = 1'b0, hold, rst_n, busy;
   logic [7:0]               res;
   logic [31:0]              exp_q[$];
   psbrc_pkg::psbrc_wb_req_t req = '0;
   psbrc_pkg::psbrc_wb_rsp_t rsp;
   int fail_count = 0, checks_done = 0, cyc_n = 0;
   always #12.5 clk = ~clk;
   psbrc_top #(.HOLD_CYCLES(H), .VOLTAGE_SELECT_FIELD_SET0(V0), .VOLTAGE_SELECT_FIELD_SET1(V1)) i_dut (
      .i_ref_clk(clk), .i_rstn(rstn), .i_wb(req), .o_wb(rsp),
      .i_hold_on_pin(hold), .i_power_button_pin(btn),
      .i_config_set_strap(cfg), .i_sequence_select_strap(sqs),
      .i_osc_stable(osc), .i_ext_clk_stable(ext),
      .o_resource_en(res), .o_proc_reset_n(rst_n), .o_seq_busy(busy));
   psbrc_host i_host (.i_ref_clk(clk), .i_keep(keep),
      .i_proc_reset_n(rst_n), .o_hold_on_pin(hold));
   // ==========================================================
   // Tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("mismatch t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      req <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:4'hF, dat:d};
      @(posedge clk);
      while (rsp.ack !== 1'b1) @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic step(input int q, input int s, input logic [1:0] op,
      input logic [3:0] g, input logic v, input logic ss);
      psbrc_pkg::psbrc_step_t p;
      p = '{op:op, arg:g, val:v, strap_sel:ss, delay:8'(1 + $urandom % 3)};
      bus(1'b1, psbrc_pkg::PROG_BASE_OFS + 8'(4 * (q * 8 + s)), {16'h0, p});
   endtask
   task automatic do_reset(input logic c, input logic s);
      @(posedge clk);
      rstn <= 1'b0;
      cfg  <= c;
      sqs  <= s;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   task automatic press();
      @(posedge clk);
      btn <= 1'b1;
      repeat (12) @(posedge clk);
      btn <= 1'b0;
   endtask
   task automatic settle(input logic v);
      while (rst_n !== v) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
   endtask
   // ==========================================================
   // Result monitor and timeout
   always @(posedge clk) begin
      if (rsp.ack === 1'b1 && !req.we && exp_q.size() > 0)
         chk(rsp.dat, exp_q.pop_front());
      cyc_n <= cyc_n + 1;
      if (cyc_n == 90000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] ctl;
      int t;
      void'($urandom(32'h8f0e));
      do_reset(1'b0, 1'b0);
      step(0, 0, psbrc_pkg::OP_SET, 4'h0, 1'b1, 1'b0);
      step(0, 1, psbrc_pkg::OP_END, 4'h0, 1'b0, 1'b0);
      step(1, 0, psbrc_pkg::OP_SET, 4'h1, 1'b1, 1'b0);
      step(1, 1, psbrc_pkg::OP_END, 4'h0, 1'b0, 1'b0);
      step(2, 0, psbrc_pkg::OP_BRANCH, 4'h3, 1'b1, 1'b1);
      step(2, 1, psbrc_pkg::OP_SET, 4'h2, 1'b1, 1'b0);
      step(2, 2, psbrc_pkg::OP_END, 4'h0, 1'b0, 1'b0);
      step(2, 3, psbrc_pkg::OP_SET, 4'h3, 1'b1, 1'b0);
      step(2, 4, psbrc_pkg::OP_END, 4'h0, 1'b0, 1'b0);
      step(3, 0, psbrc_pkg::OP_END, 4'h0, 1'b0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         do_reset(k[1], k[0]);
         osc <= k[0];
         ext <= ~k[0];
         ctl = (k == 0) ? 8'h06 : (k == 1) ? 8'h16 : 8'h0E;
         bus(1'b1, psbrc_pkg::DEVICE_CONTROL_REG_OFS, {24'h0, ctl});
         bus(1'b1, psbrc_pkg::RESOURCE_REG_OFS, 32'h0000_00FF);
         rd(psbrc_pkg::RESOURCE_REG_OFS, 32'h0);
         press();
         settle(1'b0);
         if (k < 2) begin
            rd(psbrc_pkg::STATUS_REG_OFS, {24'h0, k[0], 7'h03});
            osc <= 1'b1;
            ext <= 1'b1;
         end
         settle(1'b1);
         rd(psbrc_pkg::STATUS_REG_OFS,
            {24'h0, k[0], k[1], 3'h4, 3'h4});
         rd(psbrc_pkg::RESOURCE_REG_OFS, {24'h0, 8'h01 << k});
         chk({24'h0, res}, {24'h0, 8'h01 << k});
         rd(psbrc_pkg::SWITCHER_VOLTAGE_OFS, {25'h0, k[1] ? V1 : V0});
         rd(psbrc_pkg::SWITCHER_FORCED_OFS, {25'h0, k[1] ? V1 : V0});
         rd(psbrc_pkg::DEVICE_CONTROL_REG_OFS, {24'h0, ctl | 8'h01});
         bus(1'b1, psbrc_pkg::SWITCHER_FORCED_OFS, 32'h0000_0011);
         rd(psbrc_pkg::SWITCHER_FORCED_OFS, 32'h0000_0011);
         bus(1'b1, 8'h40, 32'hFFFF_FFFF);
         rd(8'h40, 32'h0);
         bus(1'b1, psbrc_pkg::DEVICE_CONTROL_REG_OFS, {24'h0, ctl});
         settle(1'b0);
         rd(psbrc_pkg::RESOURCE_REG_OFS, 32'h0);
         rd(psbrc_pkg::SWITCHOFF_STATUS_OFS, 32'h2);
         rd(psbrc_pkg::DEVICE_CONTROL_REG_OFS, {24'h0, ctl});
      end
      osc <= 1'b1;
      bus(1'b1, psbrc_pkg::DEVICE_CONTROL_REG_OFS, 32'h0);
      press();
      settle(1'b1);
      t = 0;
      while (rst_n === 1'b1) begin
         @(posedge clk);
         t++;
      end
      chk(32'(t >= H - 4 && t <= H + 4), 32'h1);
      settle(1'b0);
      rd(psbrc_pkg::SWITCHOFF_STATUS_OFS, 32'h2);
      bus(1'b1, psbrc_pkg::DEVICE_CONTROL_REG_OFS, 32'h0000_0001);
      press();
      settle(1'b1);
      repeat (H + 40) @(posedge clk);
      chk(32'(rst_n), 32'h1);
      bus(1'b1, psbrc_pkg::DEVICE_CONTROL_REG_OFS, 32'h0);
      settle(1'b0);
      bus(1'b1, psbrc_pkg::DEVICE_CONTROL_REG_OFS, 32'h0000_0020);
      keep <= 1'b1;
      press();
      settle(1'b1);
      repeat (H + 40) @(posedge clk);
      chk(32'(rst_n), 32'h1);
      keep <= 1'b0;
      t = 0;
      while (rst_n === 1'b1) begin
         @(posedge clk);
         t++;
      end
      chk(32'(t <= 8), 32'h1);
      settle(1'b0);
      rd(psbrc_pkg::SWITCHOFF_STATUS_OFS, 32'h1);
      rd(psbrc_pkg::DEVICE_CONTROL_REG_OFS, 32'h6);
      rd(psbrc_pkg::SWITCHER_FORCED_OFS, {25'h0, V1});
      tally_and_finish();
   end
endmodule // psbrc_top_tb
bind psbrc_top psbrc_properties i_chk (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wb(i_wb), .o_wb(o_wb),
   .i_hold_on_pin(i_hold_on_pin), .i_power_button_pin(i_power_button_pin),
   .i_config_set_strap(i_config_set_strap),
   .i_sequence_select_strap(i_sequence_select_strap),
   .i_osc_stable(i_osc_stable), .i_ext_clk_stable(i_ext_clk_stable),
   .o_resource_en(o_resource_en), .o_proc_reset_n(o_proc_reset_n),
   .o_seq_busy(o_seq_busy));
`default_nettype wire
